// ===== hdl/isp_params.svh
// constants for the shared indicator / strap pin block
// assumes a single 250 MHz clock and plain integer arithmetic at elaboration
`ifndef ISP_PARAMS_SVH
`define ISP_PARAMS_SVH

// ==========================================================
// indicator configuration field encodings
`define ISP_CFG_RESERVED    2'h0
`define ISP_CFG_FIVE        2'h1
`define ISP_CFG_FOUR        2'h2
`define ISP_CFG_SIX         2'h3
`define ISP_CFG_RESET       2'h3
`define ISP_CFG_MSB         7
`define ISP_CFG_LSB         6
`define ISP_CFG_REG_ADDR    5'h11

// ==========================================================
// station address bit positions held by the two straps
`define ISP_STRAP_BIT_GIG   3
`define ISP_STRAP_BIT_DUP   2

// ==========================================================
// timing
`define ISP_CLK_MHZ          250
`define ISP_STRAP_SETTLE_NS  1000
`define ISP_STRAP_SETTLE_CYC ((`ISP_STRAP_SETTLE_NS * `ISP_CLK_MHZ + 999) / 1000)
`define ISP_BLINK_HALF_MS    50
`define ISP_BLINK_HALF_CYC   (`ISP_BLINK_HALF_MS * `ISP_CLK_MHZ * 1000)

// ==========================================================
// pin levels (indicators are active low)
`define ISP_LVL_ON   1'b0
`define ISP_LVL_OFF  1'b1

`endif

// ===== hdl/isp_pkg.sv
// types shared by the indicator / strap pin block
// assumes isp_params.svh for all numeric constants
package isp_pkg;

   // ==========================================================
   // link status seen by the indicators
   typedef struct packed {
      logic link_1000;
      logic rx_activity;
      logic tx_activity;
      logic full_duplex;
      logic collision;
   } isp_status_s;

   // ==========================================================
   // configuration field value
   typedef logic [1:0] isp_cfg_t;

   // ==========================================================
   // power-up phase of the shared pins
   typedef enum logic [1:0] {
      ISP_SETTLE,
      ISP_SAMPLE,
      ISP_DRIVE
   } isp_phase_e;

endpackage : isp_pkg

// ===== hdl/isp_pin_ctrl.sv
// one shared pin: strap capture, then indicator drive
// assumes sample_in precedes release_in, both from the owning block
`timescale 1ns/1ns
`include "isp_params.svh"
module isp_pin_ctrl (
   input  wire logic clock_in,
   input  wire logic arst_n_in,
   input  wire logic pin_in,
   input  wire logic sample_in,
   input  wire logic release_in,
   input  wire logic level_in,
   output logic      pin_out,
   output logic      pin_oe_out,
   output logic      strap_bit_out
);

   // ==========================================================
   // strap capture, taken while the pin is still undriven
   always_ff @(posedge clock_in or negedge arst_n_in) begin
      if (!arst_n_in) begin
         strap_bit_out <= 1'b0;
      end else if (sample_in && !pin_oe_out) begin
         strap_bit_out <= pin_in;
      end
   end

   // ==========================================================
   // output enable, raised only after the strap is held
   always_ff @(posedge clock_in or negedge arst_n_in) begin
      if (!arst_n_in) begin
         pin_oe_out <= 1'b0;
      end else if (release_in) begin
         pin_oe_out <= 1'b1;
      end
   end

   // ==========================================================
   // indicator level
   always_ff @(posedge clock_in or negedge arst_n_in) begin
      if (!arst_n_in) begin
         pin_out <= `ISP_LVL_OFF;
      end else if (release_in) begin
         pin_out <= level_in;
      end else begin
         pin_out <= `ISP_LVL_OFF;
      end
   end

endmodule : isp_pin_ctrl

// ===== hdl/isp_indicator_pins.sv
// shared gigabit and duplex indicator / strap pins
// assumes status inputs synchronous to clock_in; config written by management logic
// strap pull levels are read only while both pins are undriven
//
// Contract
// - sample gigabit pin pull level after reset, hold as address bit 3
// - sample duplex pin pull level after reset, hold as address bit 2
// - two-bit config field picks pin function; value 00 is reserved
// - field resets to 11 six-pin; 01 five-pin; 10 four-pin
// - six/five-pin: gigabit pin low with gigabit link up, high otherwise
// - four-pin: gigabit pin high link down, low up, toggles on activity
// - duplex pin high half, low full duplex, toggles during collision; the code holds it high whenever the field is 00
`timescale 1ns/1ns
`include "isp_params.svh"

module isp_indicator_pins #(
   parameter int STRAP_SETTLE_CYCLES = `ISP_STRAP_SETTLE_CYC,
   parameter int BLINK_HALF_CYCLES   = `ISP_BLINK_HALF_CYC
) (
   input  wire logic                 clock_in,
   input  wire logic                 arst_n_in,
   input  wire isp_pkg::isp_status_s status_in,
   input  wire logic                 cfg_wr_in,
   input  wire isp_pkg::isp_cfg_t    cfg_data_in,
   input  wire logic                 gigabit_link_indicator_in,
   output logic                      gigabit_link_indicator_out,
   output logic                      gigabit_link_indicator_oe_out,
   input  wire logic                 duplex_collision_indicator_in,
   output logic                      duplex_collision_indicator_out,
   output logic                      duplex_collision_indicator_oe_out,
   output logic [3:2]                station_address_strap_out,
   output logic                      strap_valid_out,
   output isp_pkg::isp_cfg_t         indicator_config_field_out
);

   localparam int SETTLE_W = (STRAP_SETTLE_CYCLES > 1) ? $clog2(STRAP_SETTLE_CYCLES) : 1;
   localparam int BLINK_W  = (BLINK_HALF_CYCLES > 1) ? $clog2(BLINK_HALF_CYCLES) : 1;

   isp_pkg::isp_phase_e phase;
   isp_pkg::isp_phase_e next_phase;
   logic [SETTLE_W-1:0] settle_count;
   logic [BLINK_W-1:0]  blink_count;
   logic                blink_phase;
   logic                sample;
   logic                released;
   logic                gig_level;
   logic                dup_level;
   logic                gig_strap;
   logic                dup_strap;
   logic                blink_wrap;
   logic                gig_activity;
   logic                cfg_defined;

   // ==========================================================
   // configuration field
   always_ff @(posedge clock_in or negedge arst_n_in) begin
      if (!arst_n_in) begin
         indicator_config_field_out <= `ISP_CFG_RESET;
      end else if (cfg_wr_in) begin
         indicator_config_field_out <= cfg_data_in;
      end
   end

   // ==========================================================
   // power-up phase: settle, sample straps, then drive
   always_comb begin
      next_phase = phase;
      case (phase)
         isp_pkg::ISP_SETTLE: begin
            if (settle_count == SETTLE_W'(STRAP_SETTLE_CYCLES - 1)) begin
               next_phase = isp_pkg::ISP_SAMPLE;
            end
         end
         isp_pkg::ISP_SAMPLE: begin
            next_phase = isp_pkg::ISP_DRIVE;
         end
         isp_pkg::ISP_DRIVE: begin
            next_phase = isp_pkg::ISP_DRIVE;
         end
         default: begin
            next_phase = isp_pkg::ISP_SETTLE;
         end
      endcase
   end

   always_ff @(posedge clock_in or negedge arst_n_in) begin
      if (!arst_n_in) begin
         phase <= isp_pkg::ISP_SETTLE;
      end else begin
         phase <= next_phase;
      end
   end

   always_ff @(posedge clock_in or negedge arst_n_in) begin
      if (!arst_n_in) begin
         settle_count <= '0;
      end else if (phase == isp_pkg::ISP_SETTLE) begin
         settle_count <= settle_count + SETTLE_W'(1);
      end
   end

   assign sample   = (phase == isp_pkg::ISP_SAMPLE);
   assign released = (phase == isp_pkg::ISP_DRIVE);

   // ==========================================================
   // blink generator, free running once pins are driven
   assign blink_wrap = (blink_count == BLINK_W'(BLINK_HALF_CYCLES - 1));

   always_ff @(posedge clock_in or negedge arst_n_in) begin
      if (!arst_n_in) begin
         blink_count <= '0;
      end else if (!released) begin
         blink_count <= '0;
      end else if (blink_wrap) begin
         blink_count <= '0;
      end else begin
         blink_count <= blink_count + BLINK_W'(1);
      end
   end

   always_ff @(posedge clock_in or negedge arst_n_in) begin
      if (!arst_n_in) begin
         blink_phase <= `ISP_LVL_OFF;
      end else if (!released) begin
         blink_phase <= `ISP_LVL_OFF;
      end else if (blink_wrap) begin
         blink_phase <= ~blink_phase;
      end
   end

   // ==========================================================
   // activity and configuration decode
   assign gig_activity = status_in.rx_activity || status_in.tx_activity;
   assign cfg_defined  = (indicator_config_field_out != `ISP_CFG_RESERVED);

   // ==========================================================
   // gigabit pin function
   always_comb begin
      gig_level = `ISP_LVL_OFF;
      case (indicator_config_field_out)
         `ISP_CFG_SIX,
         `ISP_CFG_FIVE: begin
            gig_level = status_in.link_1000 ? `ISP_LVL_ON : `ISP_LVL_OFF;
         end
         `ISP_CFG_FOUR: begin
            if (!status_in.link_1000) begin
               gig_level = `ISP_LVL_OFF;
            end else if (gig_activity) begin
               gig_level = blink_phase;
            end else begin
               gig_level = `ISP_LVL_ON;
            end
         end
         default: begin
            gig_level = `ISP_LVL_OFF;
         end
      endcase
   end

   // ==========================================================
   // duplex pin function
   always_comb begin
      dup_level = `ISP_LVL_OFF;
      if (!cfg_defined) begin
         dup_level = `ISP_LVL_OFF;
      end else if (status_in.collision) begin
         dup_level = blink_phase;
      end else if (status_in.full_duplex) begin
         dup_level = `ISP_LVL_ON;
      end else begin
         dup_level = `ISP_LVL_OFF;
      end
   end

   // ==========================================================
   // pin instances
   isp_pin_ctrl u_gig_pin (
      .clock_in      (clock_in),
      .arst_n_in     (arst_n_in),
      .pin_in        (gigabit_link_indicator_in),
      .sample_in     (sample),
      .release_in    (released),
      .level_in      (gig_level),
      .pin_out       (gigabit_link_indicator_out),
      .pin_oe_out    (gigabit_link_indicator_oe_out),
      .strap_bit_out (gig_strap)
   );

   isp_pin_ctrl u_dup_pin (
      .clock_in      (clock_in),
      .arst_n_in     (arst_n_in),
      .pin_in        (duplex_collision_indicator_in),
      .sample_in     (sample),
      .release_in    (released),
      .level_in      (dup_level),
      .pin_out       (duplex_collision_indicator_out),
      .pin_oe_out    (duplex_collision_indicator_oe_out),
      .strap_bit_out (dup_strap)
   );

   // ==========================================================
   // station address strap bits
   always_ff @(posedge clock_in or negedge arst_n_in) begin
      if (!arst_n_in) begin
         station_address_strap_out <= '0;
      end else if (released) begin
         station_address_strap_out[`ISP_STRAP_BIT_GIG] <= gig_strap;
         station_address_strap_out[`ISP_STRAP_BIT_DUP] <= dup_strap;
      end
   end

   // ==========================================================
   // strap held flag
   always_ff @(posedge clock_in or negedge arst_n_in) begin
      if (!arst_n_in) begin
         strap_valid_out <= 1'b0;
      end else if (released) begin
         strap_valid_out <= 1'b1;
      end
   end

endmodule : isp_indicator_pins

// ===== sim/isp_indicator_pins_asserts.sv
// checker for the shared indicator / strap pins
// assumes bind onto isp_indicator_pins, small blink count
`timescale 1ns/1ns
`include "isp_params.svh"
module isp_indicator_pins_asserts #(
   parameter int BLINK_HALF_CYCLES = 4
) (
   input wire logic                 clock_in,
   input wire logic                 arst_n_in,
   input wire isp_pkg::isp_status_s status_in,
   input wire logic                 cfg_wr_in,
   input wire isp_pkg::isp_cfg_t    cfg_data_in,
   input wire logic                 gigabit_link_indicator_in,
   input wire logic                 gigabit_link_indicator_out,
   input wire logic                 gigabit_link_indicator_oe_out,
   input wire logic                 duplex_collision_indicator_in,
   input wire logic                 duplex_collision_indicator_out,
   input wire logic                 duplex_collision_indicator_oe_out,
   input wire logic [3:2]           station_address_strap_out,
   input wire logic                 strap_valid_out,
   input wire isp_pkg::isp_cfg_t    indicator_config_field_out
);
   // ==========================================================
   // stable-run counter of the duplex pin while colliding
   int   run;
   logic dup_prev;
   always_ff @(posedge clock_in or negedge arst_n_in) begin
      if (!arst_n_in) begin
         run      <= 0;
         dup_prev <= `ISP_LVL_OFF;
      end else begin
         dup_prev <= duplex_collision_indicator_out;
         if (!status_in.collision || indicator_config_field_out == `ISP_CFG_RESERVED
             || !duplex_collision_indicator_oe_out || duplex_collision_indicator_out != dup_prev) begin
            run <= 0;
         end else begin
            run <= run + 1;
         end
      end
   end
   // ==========================================================
   // properties
   default clocking cb @(posedge clock_in); endclocking
   default disable iff (!arst_n_in);
   sequence strap_taken;
      $rose(strap_valid_out);
   endsequence
   drive_after_strap_a: assert property (gigabit_link_indicator_oe_out |-> strap_valid_out)
      else $error("gigabit pin driven before strap capture");
   gig_strap_a: assert property (strap_taken |->
      station_address_strap_out[3] == $past(gigabit_link_indicator_in))
      else $error("gigabit strap bit wrong");
   dup_strap_a: assert property (strap_taken |->
      station_address_strap_out[2] == $past(duplex_collision_indicator_in))
      else $error("duplex strap bit wrong");
   strap_hold_a: assert property ($past(strap_valid_out) |->
      strap_valid_out && $stable(station_address_strap_out))
      else $error("strap not held");
   cfg_write_a: assert property (cfg_wr_in |=> indicator_config_field_out == $past(cfg_data_in))
      else $error("config write lost");
   gig_link_a: assert property ($past(gigabit_link_indicator_oe_out) && $past(indicator_config_field_out[0])
      |-> gigabit_link_indicator_out == !$past(status_in.link_1000))
      else $error("gigabit pin wrong in six or five mode");
   four_idle_a: assert property ($past(gigabit_link_indicator_oe_out)
      && $past(indicator_config_field_out) == `ISP_CFG_FOUR
      && !($past(status_in.rx_activity) || $past(status_in.tx_activity))
      |-> gigabit_link_indicator_out == !$past(status_in.link_1000))
      else $error("gigabit pin wrong in four mode");
   duplex_lvl_a: assert property ($past(duplex_collision_indicator_oe_out)
      && $past(indicator_config_field_out) != `ISP_CFG_RESERVED
      && !$past(status_in.collision) |-> duplex_collision_indicator_out == !$past(status_in.full_duplex))
      else $error("duplex pin wrong");
   reserved_off_a: assert property ($past(gigabit_link_indicator_oe_out)
      && $past(indicator_config_field_out) == `ISP_CFG_RESERVED
      |-> gigabit_link_indicator_out && duplex_collision_indicator_out)
      else $error("reserved mode pins not off");
   blink_period_a: assert property (run <= BLINK_HALF_CYCLES + 2)
      else $error("collision blink stalled");
endmodule : isp_indicator_pins_asserts

bind isp_indicator_pins isp_indicator_pins_asserts #(
   .BLINK_HALF_CYCLES(BLINK_HALF_CYCLES)
) i_isp_indicator_pins_asserts (
   .clock_in                          (clock_in),
   .arst_n_in                         (arst_n_in),
   .status_in                         (status_in),
   .cfg_wr_in                         (cfg_wr_in),
   .cfg_data_in                       (cfg_data_in),
   .gigabit_link_indicator_in         (gigabit_link_indicator_in),
   .gigabit_link_indicator_out        (gigabit_link_indicator_out),
   .gigabit_link_indicator_oe_out     (gigabit_link_indicator_oe_out),
   .duplex_collision_indicator_in     (duplex_collision_indicator_in),
   .duplex_collision_indicator_out    (duplex_collision_indicator_out),
   .duplex_collision_indicator_oe_out (duplex_collision_indicator_oe_out),
   .station_address_strap_out         (station_address_strap_out),
   .strap_valid_out                   (strap_valid_out),
   .indicator_config_field_out        (indicator_config_field_out)
);

// ===== sim/isp_board_model.sv
// board side: strap pull resistors on the two shared pins
// assumes the pin level is the drive while enabled, else the pull
`timescale 1ns/1ns
module isp_board_model (
   input  wire logic pull_gig_in,
   input  wire logic pull_dup_in,
   input  wire logic gig_out_in,
   input  wire logic gig_oe_in,
   input  wire logic dup_out_in,
   input  wire logic dup_oe_in,
   output logic      gig_pin_out,
   output logic      dup_pin_out
);
   assign gig_pin_out = gig_oe_in ? gig_out_in : pull_gig_in;
   assign dup_pin_out = dup_oe_in ? dup_out_in : pull_dup_in;
endmodule : isp_board_model

// ===== sim/isp_indicator_pins_bench.sv
// testbench for the shared indicator / strap pins
// assumes small settle and blink counts
`timescale 1ns/1ns
`include "isp_params.svh"
module isp_indicator_pins_bench;
   logic                clk = 0, rst_n = 0, cfg_wr = 0, pg = 0, pd = 0;
   logic                go, goe, gpin, dout, doe, dpin, valid;
   logic [3:2]          straps;
   isp_pkg::isp_cfg_t   cfg_data = 2'h0, field;
   isp_pkg::isp_status_s st = '0;
   int                  errors = 0, checks_done = 0;
   always #2 clk = ~clk;
   isp_indicator_pins #(.STRAP_SETTLE_CYCLES(4), .BLINK_HALF_CYCLES(4)) i_isp_indicator_pins (
      .clock_in(clk), .arst_n_in(rst_n), .status_in(st), .cfg_wr_in(cfg_wr), .cfg_data_in(cfg_data),
      .gigabit_link_indicator_in(gpin), .gigabit_link_indicator_out(go), .gigabit_link_indicator_oe_out(goe),
      .duplex_collision_indicator_in(dpin), .duplex_collision_indicator_out(dout),
      .duplex_collision_indicator_oe_out(doe), .station_address_strap_out(straps),
      .strap_valid_out(valid), .indicator_config_field_out(field));
   isp_board_model i_isp_board_model (.pull_gig_in(pg), .pull_dup_in(pd), .gig_out_in(go), .gig_oe_in(goe),
      .dup_out_in(dout), .dup_oe_in(doe), .gig_pin_out(gpin), .dup_pin_out(dpin));
   // ==========================================================
   // helpers
   task chk(input string name, input logic [3:0] exp, input logic [3:0] got);
      checks_done++;
      if (got !== exp) begin
         errors++;
         $display("[ERR] %s expected %h seen %h", name, exp, got);
      end
   endtask : chk
   task end_of_test;
      if (errors == 0 && checks_done > 0) begin
         $display("*** PASS ***");
      end else begin
         $display("*** FAIL ***");
      end
      $finish;
   endtask : end_of_test
   // ==========================================================
   // scenarios
   task t_reset(input logic g, input logic d);
      int n;
      @(posedge clk);
      rst_n <= 0;
      pg <= g;
      pd <= d;
      repeat (10) @(posedge clk);
      #1 chk("reset_field", 4'h3, field);
      chk("reset_oe", 4'h0, {goe, doe, valid});
      @(posedge clk);
      rst_n <= 1;
      n = 0;
      while (valid !== 1'b1 && n < 20) begin
         @(posedge clk);
         #1 n++;
      end
      chk("straps", {g, d}, straps);
      chk("oe", 4'h3, {goe, doe});
   endtask : t_reset
   task t_mode(input isp_pkg::isp_cfg_t c, input logic lk, input logic fd, input logic [1:0] e);
      @(posedge clk);
      cfg_wr <= 1;
      cfg_data <= c;
      st <= {lk, 1'b0, 1'b0, fd, 1'b0};
      @(posedge clk);
      cfg_wr <= 0;
      repeat (2) @(posedge clk);
      #1 chk("field", c, field);
      chk("pins", e, {go, dout});
   endtask : t_mode
   task t_blink;
      int   gt, dt;
      logic gp, dp;
      gt = 0;
      dt = 0;
      @(posedge clk);
      cfg_wr <= 1;
      cfg_data <= `ISP_CFG_FOUR;
      st <= 5'b11001;
      @(posedge clk);
      cfg_wr <= 0;
      #1 gp = go;
      dp = dout;
      repeat (24) begin
         @(posedge clk);
         #1 if (go !== gp) gt++;
         if (dout !== dp) dt++;
         gp = go;
         dp = dout;
      end
      chk("gig_toggles", 4'h1, 4'(gt >= 5 && gt <= 7));
      chk("dup_toggles", 4'h1, 4'(dt >= 5 && dt <= 7));
      @(posedge clk);
      st <= '0;
   endtask : t_blink
   // ==========================================================
   // main sequence and watchdog
   initial begin
      t_reset(1'b1, 1'b0);
      t_mode(`ISP_CFG_SIX, 1'b1, 1'b1, 2'b00);
      t_mode(`ISP_CFG_FIVE, 1'b0, 1'b0, 2'b11);
      t_mode(`ISP_CFG_FOUR, 1'b1, 1'b0, 2'b01);
      t_mode(`ISP_CFG_FOUR, 1'b0, 1'b1, 2'b10);
      t_mode(`ISP_CFG_RESERVED, 1'b1, 1'b1, 2'b11);
      t_blink();
      t_reset(1'b0, 1'b1);
      end_of_test();
   end
   initial begin
      #20000;
      errors++;
      end_of_test();
   end
endmodule : isp_indicator_pins_bench
